// ### core_bus_model.sv
// Processor core model issuing accesses to the TLB port
`default_nettype none
module core_bus_model
  import tlb_map_pkg::*;
(
  // Clock
  input  wire logic                clk,
  // Request to the port
  output var tlb_map_pkg::tlb_req_s req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Mode is {fetch, privileged, longword}; held until the next call
  task automatic acc(input logic [1:0] op, input logic [2:0] md,
                     input logic [31:0] a, input logic [31:0] d);
    req.wr         <= op[1];
    req.rd         <= op[0];
    req.fetch      <= md[2];
    req.privileged <= md[1];
    req.longword   <= md[0];
    req.addr       <= a;
    req.wdata      <= d;
    @(posedge clk);
  endtask
  // Released lines flip so a stale value is never mistaken for a request
  task automatic idle();
    req.wr    <= 1'b0;
    req.rd    <= 1'b0;
    req.addr  <= ~req.addr;
    req.wdata <= ~req.wdata;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### tlb_index_gen.sv
// Entry index and way selection for one array access
`default_nettype none
module tlb_index_gen
  import tlb_map_pkg::*;
(
  // Access address and control
  input  wire logic [31:0]        addr,
  input  wire logic               index_hash_select,
  input  wire logic [7:0]         address_space_id,
  // Selection
  output logic [ENTRY_W-1:0]      entry_idx,
  output logic [WAY_W-1:0]        way_sel
);
  wire logic [ENTRY_W-1:0] raw_idx;

  assign raw_idx   = addr[ENTRY_HI:ENTRY_LO];
  // Hash uses the low bits of the current space identifier
  assign entry_idx = index_hash_select ?
                     (raw_idx ^ address_space_id[ENTRY_W-1:0]) :
                     raw_idx;
  assign way_sel   = addr[WAY_HI:WAY_LO];
endmodule
`default_nettype wire

// ### tlb_map_pkg.sv
// Package for the memory-mapped TLB access port: map, field layout, types
package tlb_map_pkg;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  localparam logic [7:0] ADDR_ARRAY_TOP = 8'hf2;
  localparam logic [7:0] DATA_ARRAY_TOP = 8'hf3;
  localparam int         TOP_HI         = 31;
  localparam int         TOP_LO         = 24;
  localparam int         ENTRY_HI       = 16;
  localparam int         ENTRY_LO       = 12;
  localparam int         WAY_HI         = 9;
  localparam int         WAY_LO         = 8;
  localparam int         ENTRY_W        = 5;
  localparam int         WAY_W          = 2;
  localparam int         NUM_WAYS       = 4;
  localparam int         NUM_ENTRIES    = 32;

  // ****************************************************************
  // Address array word layout
  // ****************************************************************
  localparam int VPN_HI_HI = 31;
  localparam int VPN_HI_LO = 17;
  localparam int VPN_LO_HI = 11;
  localparam int VPN_LO_LO = 10;
  localparam int VALID_BIT = 8;
  localparam int ADDRESS_SPACE_ID_HI   = 7;
  localparam int ADDRESS_SPACE_ID_LO   = 0;

  // ****************************************************************
  // Data array word layout
  // ****************************************************************
  localparam int PPN_HI    = 28;
  localparam int PPN_LO    = 10;
  localparam int PROT_HI   = 6;
  localparam int PROT_LO   = 5;
  localparam int SIZE_BIT  = 4;
  localparam int CACHE_BIT = 3;
  localparam int DIRTY_BIT = 2;
  localparam int SHARE_BIT = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // Stored entry, one per entry and way
  typedef struct packed {
    logic [16:0] virtual_page_number;
    logic        valid;
    logic [7:0]  address_space_id;
    logic [18:0] physical_page_number;
    logic [1:0]  protection_key;
    logic        page_size_bit;
    logic        cacheable;
    logic        dirty;
    logic        share_status_flag;
  } tlb_entry_s;

  // Core-side access request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic        fetch;
    logic        privileged;
    logic        longword;
  } tlb_req_s;

endpackage

// ### tlb_mmap_port.sv
// Memory-mapped access port into the TLB address and data arrays
`default_nettype none
module tlb_mmap_port
  import tlb_map_pkg::*;
#(
  parameter int ENTRIES = NUM_ENTRIES,
  parameter int WAYS    = NUM_WAYS
)(
  // Clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST,
  // Core access port
  input  wire tlb_map_pkg::tlb_req_s REQ,
  output logic [31:0]               RDATA,
  output logic                      RVALID,
  output logic                      ACC_ERR,
  // MMU control and translation state
  input  wire logic                 INDEX_HASH_SELECT,
  input  wire logic [7:0]           CUR_ADDRESS_SPACE_ID,
  // Lookup side view of the selected entry valid bits
  input  wire logic [4:0]           LOOKUP_IDX,
  output logic [3:0]                LOOKUP_VALID
);
  import tlb_map_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Each way keeps its own array in g_way; these carry selections out
  wire tlb_entry_s      way_entry [WAYS];
  wire logic [WAYS-1:0] lookup_v;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire logic [7:0]         top_byte;
  wire logic               hit_addr;
  wire logic               hit_data;
  wire logic               allowed;
  wire logic               wr_ok;
  wire logic               rd_ok;
  wire logic               bad;
  wire logic [ENTRY_W-1:0] idx;
  wire logic [WAY_W-1:0]   way;
  tlb_entry_s              cur;
  tlb_entry_s              wr_entry;
  logic [31:0]             addr_word;
  logic [31:0]             data_word;
  logic [31:0]             rdata_d;

  assign top_byte = REQ.addr[TOP_HI:TOP_LO];
  assign hit_addr = (top_byte == ADDR_ARRAY_TOP);
  assign hit_data = (top_byte == DATA_ARRAY_TOP);
  // Narrow, user or fetch cycles leave the arrays untouched
  assign allowed  = REQ.privileged && REQ.longword
                    && !REQ.fetch;
  assign wr_ok    = REQ.wr && allowed && (hit_addr || hit_data);
  assign rd_ok    = REQ.rd && allowed && (hit_addr || hit_data);
  assign bad      = (REQ.wr || REQ.rd) && (hit_addr || hit_data) && !allowed;

  tlb_index_gen u_index (
    .addr              (REQ.addr),
    .index_hash_select (INDEX_HASH_SELECT),
    .address_space_id  (CUR_ADDRESS_SPACE_ID),
    .entry_idx         (idx),
    .way_sel           (way)
  );

  assign cur = way_entry[way];

  // ****************************************************************
  // Word packing
  // ****************************************************************
  always_comb begin
    addr_word = 32'h0000_0000;
    addr_word[VPN_HI_HI:VPN_HI_LO] = cur.virtual_page_number[16:2];
    addr_word[VPN_LO_HI:VPN_LO_LO] = cur.virtual_page_number[1:0];
    addr_word[VALID_BIT]           = cur.valid;
    addr_word[ADDRESS_SPACE_ID_HI:ADDRESS_SPACE_ID_LO]     = cur.address_space_id;
  end

  always_comb begin
    data_word = 32'h0000_0000;
    data_word[PPN_HI:PPN_LO]   = cur.physical_page_number;
    data_word[VALID_BIT]       = cur.valid;
    data_word[PROT_HI:PROT_LO] = cur.protection_key;
    data_word[SIZE_BIT]        = cur.page_size_bit;
    data_word[CACHE_BIT]       = cur.cacheable;
    data_word[DIRTY_BIT]       = cur.dirty;
    data_word[SHARE_BIT]       = cur.share_status_flag;
  end

  always_comb begin
    wr_entry = cur;
    if (hit_addr) begin
      wr_entry.virtual_page_number = {REQ.wdata[VPN_HI_HI:VPN_HI_LO],
                                      REQ.wdata[VPN_LO_HI:VPN_LO_LO]};
      wr_entry.valid               = REQ.wdata[VALID_BIT];
      wr_entry.address_space_id    = REQ.wdata[ADDRESS_SPACE_ID_HI:ADDRESS_SPACE_ID_LO];
    end else begin
      wr_entry.physical_page_number = REQ.wdata[PPN_HI:PPN_LO];
      wr_entry.valid                = REQ.wdata[VALID_BIT];
      wr_entry.protection_key       = REQ.wdata[PROT_HI:PROT_LO];
      wr_entry.page_size_bit        = REQ.wdata[SIZE_BIT];
      wr_entry.cacheable            = REQ.wdata[CACHE_BIT];
      wr_entry.dirty                = REQ.wdata[DIRTY_BIT];
      wr_entry.share_status_flag    = REQ.wdata[SHARE_BIT];
    end
  end

  always_comb begin
    rdata_d = RDATA_RST;
    if (rd_ok) begin
      rdata_d = hit_addr ? addr_word : data_word;
    end
  end

  // ****************************************************************
  // Array update, one generate per way
  // ****************************************************************
  genvar gw;
  generate
    for (gw = 0; gw < WAYS; gw++) begin : g_way
      tlb_entry_s entry_q [ENTRIES];
      wire logic  sel;
      assign sel = wr_ok && (way == WAY_W'(gw));
      always_ff @(posedge CLK_SYS) begin
        if (RST) begin
          // Only valid bits are cleared; contents are software's job
          for (int e = 0; e < ENTRIES; e++) begin
            entry_q[e].valid <= 1'b0;
          end
        end else if (sel) begin
          entry_q[idx] <= wr_entry;
        end
      end
      assign way_entry[gw] = entry_q[idx];
      // Cleared valid reaches LOOKUP_VALID one clock after the array write
      assign lookup_v[gw]  = entry_q[LOOKUP_IDX].valid;
    end
  endgenerate

  // ****************************************************************
  // Read answer
  // ****************************************************************
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      RDATA        <= RDATA_RST;
      RVALID       <= 1'b0;
      ACC_ERR      <= 1'b0;
      LOOKUP_VALID <= 4'h0;
    end else begin
      RDATA        <= rdata_d;
      RVALID       <= rd_ok;
      ACC_ERR      <= bad;
      LOOKUP_VALID <= lookup_v;
    end
  end
endmodule
`default_nettype wire

// ### tlb_mmap_port_sva.sv
// Checker for the memory-mapped TLB access port
`default_nettype none
module tlb_mmap_port_sva
  import tlb_map_pkg::*;
#(
  parameter int ENTRIES = NUM_ENTRIES,
  parameter int WAYS    = NUM_WAYS
)(
  // Clock and reset
  input wire logic                  CLK_SYS,
  input wire logic                  RST,
  // Core port
  input wire tlb_map_pkg::tlb_req_s REQ,
  input wire logic [31:0]           RDATA,
  input wire logic                  RVALID,
  input wire logic                  ACC_ERR
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] top;
  logic       hit;
  logic       ok;
  assign top = REQ.addr[31:24];
  assign hit = (REQ.rd | REQ.wr)
             & (top == ADDR_ARRAY_TOP | top == DATA_ARRAY_TOP);
  assign ok  = hit & REQ.privileged & REQ.longword & ~REQ.fetch;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_read_answer: assert property (REQ.rd && ok |=> RVALID)
    else $error("accepted read got no answer");
  chk_no_stray: assert property (!(REQ.rd && ok) |=> !RVALID)
    else $error("answer without accepted read");
  chk_refuse_flag: assert property (hit && !ok |=> ACC_ERR && !RVALID)
    else $error("refused access not flagged");
  chk_no_false_err: assert property (!(hit && !ok) |=> !ACC_ERR)
    else $error("error flag without refused access");
  chk_idle_zero: assert property (!RVALID |-> RDATA == 32'h0)
    else $error("read data not zero outside answer");
  chk_addr_unused: assert property (REQ.rd && ok && top == ADDR_ARRAY_TOP
    |=> (RDATA & 32'h0001_f200) == 32'h0) else $error("address word junk");
  chk_data_unused: assert property (REQ.rd && ok && top == DATA_ARRAY_TOP
    |=> (RDATA & 32'he000_0281) == 32'h0) else $error("data word junk");
  chk_fetch_denied: assert property (REQ.fetch && hit |=> !RVALID)
    else $error("fetch from array answered");
  cover property (REQ.rd && ok && top == ADDR_ARRAY_TOP);
  cover property (REQ.rd && ok && top == DATA_ARRAY_TOP);
  cover property (hit && !ok);
endmodule
bind tlb_mmap_port tlb_mmap_port_sva #(.ENTRIES(ENTRIES), .WAYS(WAYS)) i_sva (
  .CLK_SYS(CLK_SYS), .RST(RST), .REQ(REQ), .RDATA(RDATA),
  .RVALID(RVALID), .ACC_ERR(ACC_ERR));
`default_nettype wire

// ### tlb_mmap_port_tb.sv
// Self-checking testbench for the memory-mapped TLB access port
`default_nettype none
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %s", $time, m); end end
module tlb_mmap_port_tb;
  import tlb_map_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys;
  logic        rst = 1'b1;
  tlb_req_s    req;
  logic [31:0] rdata;
  logic        rvalid;
  logic        acc_err;
  logic        hash_sel = 1'b0;
  logic [7:0]  cur_address_space_id = 8'h00;
  logic [3:0]  lookup_valid;
  int          n_fail = 0;
  int          checks = 0;
  int          n_err = 0;
  int          cyc = 0;
  logic [31:0] exp_q[$];
  logic [2:0]  bad[3] = '{3'b001, 3'b010, 3'b111};
  core_bus_model i_core_bus_model (.clk(clk_sys), .req(req));
  tlb_mmap_port i_tlb_mmap_port (.CLK_SYS(clk_sys), .RST(rst), .REQ(req),
    .RDATA(rdata), .RVALID(rvalid), .ACC_ERR(acc_err),
    .INDEX_HASH_SELECT(hash_sel), .CUR_ADDRESS_SPACE_ID(cur_address_space_id),
    .LOOKUP_IDX(5'h05), .LOOKUP_VALID(lookup_valid));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // Answers are matched in order against what each read expects
  always @(negedge clk_sys) begin
    if (rvalid === 1'b1) `CHK(rdata, exp_q.pop_front(), "read data")
    if (acc_err === 1'b1) n_err++;
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    i_core_bus_model.acc(2'b10, 3'b011, a, d);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    i_core_bus_model.acc(2'b01, 3'b011, a, 32'h0);
  endtask
  task automatic pause();
    i_core_bus_model.idle();
    i_core_bus_model.idle();
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(lookup_valid, 4'b0000, "valid after reset")
    for (int w = 0; w < 4; w++) begin
      wr(32'hf200_5000 | 32'(w) << 8, 32'hffff_ff00 | 32'(w));
    end
    for (int w = 0; w < 4; w++) begin
      rd(32'hf200_5000 | 32'(w) << 8, 32'hfffe_0d00 | 32'(w));
    end
    $display("test address array done");
    for (int w = 0; w < 4; w++) begin
      wr(32'hf300_5000 | 32'(w) << 8, ~(32'(w) << 10));
    end
    for (int w = 0; w < 4; w++) begin
      rd(32'hf300_5000 | 32'(w) << 8, ~(32'(w) << 10) & 32'h1fff_fd7e);
    end
    wr(32'hf300_5000, 32'h0);
    rd(32'hf200_5000, 32'hfffe_0c00);
    pause();
    `CHK(lookup_valid, 4'b1110, "data array invalidate")
    $display("test data array done");
    wr(32'hf200_5100, 32'h1547_381c);
    rd(32'hf200_5100, 32'h1546_081c);
    pause();
    `CHK(lookup_valid, 4'b1100, "address array invalidate")
    hash_sel <= 1'b1;
    cur_address_space_id <= 8'h03;
    wr(32'hf200_6200, 32'h0000_0155);
    hash_sel <= 1'b0;
    rd(32'hf200_5200, 32'h0000_0155);
    $display("test invalidate and hash done");
    for (int i = 0; i < 3; i++) begin
      i_core_bus_model.acc(2'b10, bad[i], 32'hf200_5300, 32'h0);
      i_core_bus_model.acc(2'b01, bad[i], 32'hf200_5300, 32'h0);
    end
    i_core_bus_model.acc(2'b10, 3'b011, 32'hf400_5300, 32'h0);
    i_core_bus_model.acc(2'b01, 3'b011, 32'hf100_5300, 32'h0);
    rd(32'hf200_5300, 32'hfffe_0d03);
    pause();
    `CHK(n_err, 6, "refused count")
    `CHK(exp_q.size(), 0, "missing answers")
    $display("test refusals done");
    end_sim();
  end
endmodule
`default_nettype wire
